// ==== verilog/spp_pkg.sv ====
package spp_pkg;
   // Control word layout, written and read as one byte
   localparam int CTL_RATE_LO = 0;
   localparam int CTL_RATE_HI = 1;
   localparam int CTL_PHASE = 2;
   localparam int CTL_POLARITY = 3;
   localparam int CTL_CONTROLLER = 4;
   localparam int CTL_LSB_FIRST = 5;
   localparam int CTL_ENABLE = 6;
   localparam int CTL_SEL_OE = 7;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // Serial clock dividers for rate codes 00..11
   localparam int DIV_R0 = 8;
   localparam int DIV_R1 = 32;
   localparam int DIV_R2 = 128;
   localparam int DIV_R3 = 256;
   localparam int HALF_W = 7;
   localparam logic [HALF_W-1:0] HALF_R0 = HALF_W'(DIV_R0 / 2 - 1);
   localparam logic [HALF_W-1:0] HALF_R1 = HALF_W'(DIV_R1 / 2 - 1);
   localparam logic [HALF_W-1:0] HALF_R2 = HALF_W'(DIV_R2 / 2 - 1);
   localparam logic [HALF_W-1:0] HALF_R3 = HALF_W'(DIV_R3 / 2 - 1);

   // Two serial clock edges per bit, eight bits per byte
   localparam int EDGE_W = 5;
   localparam logic [EDGE_W-1:0] EDGE_LAST = 5'h10;
   localparam logic [EDGE_W-1:0] EDGE_NONE = 5'h00;

   typedef enum logic {SPP_IDLE, SPP_SHIFT} spp_state_t;
endpackage : spp_pkg

// ==== verilog/spp_sync.sv ====
`timescale 1ns/10ps
// Two flop synchroniser for pin inputs
module spp_sync #(
   parameter int WIDTH = 3
) (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic [WIDTH-1:0] d_in,
   input wire logic [WIDTH-1:0] rst_val_in,
   output logic [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] q_reg;

   // Reset to all ones: pins idle high through pull-ups
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         meta_reg <= '1;
         q_reg <= '1;
      end else begin
         meta_reg <= d_in;
         q_reg <= meta_reg;
      end
   end

   assign q_out = q_reg;
endmodule : spp_sync

// ==== verilog/spp_div.sv ====
`timescale 1ns/10ps
// Half period tick generator for the controller serial clock
module spp_div #(
   parameter int CNT_W = 7
) (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic run_in,
   input wire logic [CNT_W-1:0] half_in,
   output logic tick_out
);
   logic [CNT_W-1:0] cnt_reg;

   // Held at zero while idle so each byte starts with a full half period
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cnt_reg <= '0;
      end else if (!run_in || tick_out) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + CNT_W'(1);
      end
   end

   assign tick_out = run_in && (cnt_reg == half_in);
endmodule : spp_div

// ==== verilog/spp_port.sv ====
`timescale 1ns/10ps
// Function
// - Polarity only sets the idle level of the serial clock.
// - Phase 0 samples on first edge, phase 1 on second edge.
// - Both ends share phase and polarity; four clock formats.
// - Phase 0 target writing data while selected flags write collision.
// - Phase 1: select may stay low across bytes.
// - A finished byte is copied to a separate read buffer.
// - Byte done while buffer unread: overrun set, new byte dropped.
// - Most significant bit first unless low-bit-first is set.
// - Data write during transfer flags collision, transfer unchanged.
// - Collision detection works as controller and as target.
// - Write collision flag is cleared only by software.
// - Transfer done flag set when a byte exchange completes.
// - Interrupt needs done or mode fault flag, port enable and global enable.
// - Transfer done flag stays set until software clears it.
// - Mode fault clears controller and enable bits, requests interrupt.
// - Mode fault flag set when controller and select input low.
// - Select pin as output inhibits mode fault.
// - Mode fault flag is cleared only by software.
// - Controller clock is system clock over 8, 32, 128 or 256.
// - Only a controller starts a transfer, on a data write.
// - Target aborts and idles whenever select goes high.
// - Select takeover/output codes 00 fault; 10 and 11 do not.
module spp_port (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // Control word access
   input wire logic ctl_wr_in,
   input wire logic [7:0] ctl_data_in,
   output logic [7:0] ctl_out,
   input wire logic select_pin_takeover_in,
   input wire logic port_irq_enable_in,
   input wire logic global_irq_enable_in,
   // Data access
   input wire logic data_wr_in,
   input wire logic [7:0] data_in,
   input wire logic data_rd_in,
   output logic [7:0] data_out,
   // Flags and their clears
   input wire logic done_clr_in,
   input wire logic overrun_clr_in,
   input wire logic collision_clr_in,
   input wire logic fault_clr_in,
   output logic transfer_done_flag_out,
   output logic overrun_flag_out,
   output logic write_collision_flag_out,
   output logic mode_fault_flag_out,
   output logic busy_out,
   output logic irq_out,
   // Serial pins
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe_out,
   input wire logic ctrl_data_pin_in,
   output logic ctrl_data_pin_out,
   output logic ctrl_data_pin_oe_out,
   input wire logic tgt_data_pin_in,
   output logic tgt_data_pin_out,
   output logic tgt_data_pin_oe_out,
   input wire logic select_n_pin_in,
   output logic select_n_pin_out,
   output logic select_n_pin_oe_out
);
   logic [7:0] ctl_reg;
   logic [7:0] shift_reg;
   logic [7:0] rx_buf_reg;
   logic rx_unread_reg;
   logic out_bit_reg;
   logic sclk_lvl_reg;
   logic sclk_prev_reg;
   logic [spp_pkg::EDGE_W-1:0] edge_cnt_reg;
   spp_pkg::spp_state_t state_reg;
   logic done_reg;
   logic ovr_reg;
   logic write_collision_flag_reg;
   logic mode_fault_flag_reg;

   // Pin inputs, synchronised
   logic [2:0] pins_s;
   logic sclk_s;
   logic mosi_s;
   logic ss_n_s;
   logic miso_s;

   spp_sync #(.WIDTH(3)) u_sync (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .d_in({serial_clock_pin_in, ctrl_data_pin_in, select_n_pin_in}),
      .rst_val_in(3'h7),
      .q_out(pins_s)
   );
   // Target data input read only when controller; separate sync pair
   logic miso_meta_reg;
   logic miso_reg;
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         miso_meta_reg <= 1'h1;
         miso_reg <= 1'h1;
      end else begin
         miso_meta_reg <= tgt_data_pin_in;
         miso_reg <= miso_meta_reg;
      end
   end
   assign sclk_s = pins_s[2];
   assign mosi_s = pins_s[1];
   assign ss_n_s = pins_s[0];
   assign miso_s = miso_reg;

   // Control field decode
   wire enable = ctl_reg[spp_pkg::CTL_ENABLE];
   wire ctrl_mode = ctl_reg[spp_pkg::CTL_CONTROLLER];
   wire phase = ctl_reg[spp_pkg::CTL_PHASE];
   wire polarity = ctl_reg[spp_pkg::CTL_POLARITY];
   wire lsb_first = ctl_reg[spp_pkg::CTL_LSB_FIRST];
   wire sel_oe = ctl_reg[spp_pkg::CTL_SEL_OE];
   wire [1:0] rate = ctl_reg[spp_pkg::CTL_RATE_HI:spp_pkg::CTL_RATE_LO];

   // Rate select to half period count
   wire [spp_pkg::HALF_W-1:0] half_sel =
      (rate == 2'h0) ? spp_pkg::HALF_R0 :
      (rate == 2'h1) ? spp_pkg::HALF_R1 :
      (rate == 2'h2) ? spp_pkg::HALF_R2 : spp_pkg::HALF_R3;

   wire shifting = (state_reg == spp_pkg::SPP_SHIFT);
   wire is_ctrl = enable && ctrl_mode;
   wire is_tgt = enable && !ctrl_mode;
   wire tgt_sel = is_tgt && !ss_n_s;
   wire tick;

   spp_div #(.CNT_W(spp_pkg::HALF_W)) u_div (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .run_in(is_ctrl && shifting),
      .half_in(half_sel),
      .tick_out(tick)
   );

   // Fault when select input low, pin not taken over and sel_oe clear
   wire fault_det = ctrl_mode && !select_pin_takeover_in && !sel_oe
      && !ss_n_s;

   // Serial clock edges: own divider as controller, pin as target
   wire pin_edge = sclk_s ^ sclk_prev_reg;
   wire edge_evt = shifting && !fault_det &&
      (is_ctrl ? tick : (tgt_sel && pin_edge));
   wire [spp_pkg::EDGE_W-1:0] edge_num = edge_cnt_reg + spp_pkg::EDGE_W'(1);
   // Sample on odd edges for phase 0 and even edges for phase 1
   wire sample_edge = edge_evt && (edge_num[0] != phase);
   wire drive_edge = edge_evt && !sample_edge;
   wire byte_done = edge_evt && (edge_num == spp_pkg::EDGE_LAST);

   // Serial input bit and next output bit depend on bit order
   wire rx_bit = is_ctrl ? miso_s : mosi_s;
   wire [7:0] shift_in = lsb_first ? {rx_bit, shift_reg[7:1]} :
      {shift_reg[6:0], rx_bit};
   wire head_bit = lsb_first ? shift_reg[0] : shift_reg[7];

   // Collision: write while busy, or phase 0 target write while selected
   wire busy = shifting && (is_ctrl || (edge_cnt_reg != spp_pkg::EDGE_NONE));
   wire collide = data_wr_in && (busy || (tgt_sel && !phase));
   wire load = data_wr_in && !collide;
   wire start = load && is_ctrl && !shifting && !fault_det;
   wire overrun = byte_done && rx_unread_reg;
   // Deselect, disable or fault ends a byte early, clock back to idle
   wire abort = shifting &&
      (!enable || fault_det || (!ctrl_mode && ss_n_s));

   // Control word; mode fault clears controller and enable
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctl_reg <= spp_pkg::CTL_RESET;
      end else if (fault_det) begin
         ctl_reg <= (ctl_wr_in ? ctl_data_in : ctl_reg) &
            ~(8'h01 << spp_pkg::CTL_ENABLE) &
            ~(8'h01 << spp_pkg::CTL_CONTROLLER);
      end else if (ctl_wr_in) begin
         ctl_reg <= ctl_data_in;
      end
   end

   // Transfer sequencer; target drops back to idle when deselected
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_reg <= spp_pkg::SPP_IDLE;
         edge_cnt_reg <= spp_pkg::EDGE_NONE;
      end else begin
         unique case (state_reg)
            spp_pkg::SPP_IDLE: begin
               edge_cnt_reg <= spp_pkg::EDGE_NONE;
               if (start || tgt_sel) begin
                  state_reg <= spp_pkg::SPP_SHIFT;
               end
            end
            spp_pkg::SPP_SHIFT: begin
               if (abort) begin
                  state_reg <= spp_pkg::SPP_IDLE;
                  edge_cnt_reg <= spp_pkg::EDGE_NONE;
               end else if (byte_done) begin
                  edge_cnt_reg <= spp_pkg::EDGE_NONE;
                  // Target keeps shifting while select stays low
                  if (is_ctrl) begin
                     state_reg <= spp_pkg::SPP_IDLE;
                  end
               end else if (edge_evt) begin
                  edge_cnt_reg <= edge_num;
               end
            end
         endcase
      end
   end

   // Shifter, serial clock level and output bit
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         shift_reg <= spp_pkg::DATA_RESET;
         out_bit_reg <= 1'h0;
         sclk_lvl_reg <= 1'h0;
         sclk_prev_reg <= 1'h1;
      end else begin
         sclk_prev_reg <= sclk_s;
         if (load) begin
            shift_reg <= data_in;
         end else if (sample_edge) begin
            shift_reg <= shift_in;
         end
         // Idle level returns between bytes; polarity only inverts it
         if (!shifting || byte_done || abort) begin
            sclk_lvl_reg <= 1'h0;
         end else if (edge_evt) begin
            sclk_lvl_reg <= !sclk_lvl_reg;
         end
         // First bit presented before the first edge for phase 0
         if (edge_cnt_reg == spp_pkg::EDGE_NONE && !edge_evt) begin
            out_bit_reg <= load ? (lsb_first ? data_in[0] : data_in[7])
               : head_bit;
         end else if (drive_edge) begin
            out_bit_reg <= head_bit;
         end
      end
   end

   // Read buffer: copied at byte end unless previous byte unread
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rx_buf_reg <= spp_pkg::DATA_RESET;
         rx_unread_reg <= 1'h0;
      end else begin
         if (byte_done && !rx_unread_reg) begin
            // Phase 0 ends on a drive edge: the shifter is already whole
            rx_buf_reg <= sample_edge ? shift_in : shift_reg;
            rx_unread_reg <= 1'h1;
         end else if (data_rd_in) begin
            rx_unread_reg <= 1'h0;
         end
      end
   end

   // Sticky flags: a set in the same cycle as a clear wins
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         done_reg <= 1'h0;
         ovr_reg <= 1'h0;
         write_collision_flag_reg <= 1'h0;
         mode_fault_flag_reg <= 1'h0;
      end else begin
         done_reg <= byte_done || (done_reg && !done_clr_in);
         ovr_reg <= overrun || (ovr_reg && !overrun_clr_in);
         write_collision_flag_reg <= collide || (write_collision_flag_reg && !collision_clr_in);
         mode_fault_flag_reg <= fault_det || (mode_fault_flag_reg && !fault_clr_in);
      end
   end

   // Register outputs
   assign ctl_out = ctl_reg;
   assign data_out = rx_buf_reg;
   assign transfer_done_flag_out = done_reg;
   assign overrun_flag_out = ovr_reg;
   assign write_collision_flag_out = write_collision_flag_reg;
   assign mode_fault_flag_out = mode_fault_flag_reg;
   assign busy_out = busy;
   assign irq_out = (done_reg || mode_fault_flag_reg) && port_irq_enable_in
      && global_irq_enable_in;

   // Pin drive: controller owns clock and data out, target drives when on and selected
   assign serial_clock_pin_out = polarity ^ sclk_lvl_reg;
   assign serial_clock_pin_oe_out = is_ctrl;
   assign ctrl_data_pin_out = out_bit_reg;
   assign ctrl_data_pin_oe_out = is_ctrl;
   assign tgt_data_pin_out = out_bit_reg;
   assign tgt_data_pin_oe_out = tgt_sel;
   // Automatic select output low during each controller byte
   assign select_n_pin_out = !shifting;
   assign select_n_pin_oe_out = is_ctrl && select_pin_takeover_in && sel_oe;

   // Checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);

   sequence ctrl_start_s;
      start;
   endsequence
   sequence fault_s;
      fault_det;
   endsequence

   coll_keeps_data_a: assert property (collide |=> $stable(shift_reg)
      || $past(sample_edge)) else $error("collision loaded shifter");
   coll_flag_a: assert property (collide |=> write_collision_flag_reg)
      else $error("collision flag not set");
   write_collision_flag_sticky_a: assert property (write_collision_flag_reg && !collision_clr_in |=> write_collision_flag_reg)
      else $error("collision flag lost");
   done_sticky_a: assert property (done_reg && !done_clr_in |=> done_reg)
      else $error("done flag lost");
   done_set_a: assert property (byte_done |=> done_reg)
      else $error("done flag not set");
   ovr_hold_a: assert property (overrun |=> ovr_reg && $stable(rx_buf_reg))
      else $error("overrun did not keep old byte");
   buf_copy_a: assert property (byte_done && !rx_unread_reg |=>
      rx_unread_reg) else $error("byte not buffered");
   irq_gate_a: assert property (irq_out |-> port_irq_enable_in &&
      global_irq_enable_in) else $error("interrupt not gated");
   fault_clear_a: assert property (fault_s |=> !ctl_reg[
      spp_pkg::CTL_ENABLE] && !ctl_reg[spp_pkg::CTL_CONTROLLER] && mode_fault_flag_reg)
      else $error("mode fault did not clear bits");
   fault_inhibit_a: assert property (select_pin_takeover_in |-> !fault_det)
      else $error("fault with select pin taken over");
   mode_fault_flag_sticky_a: assert property (mode_fault_flag_reg && !fault_clr_in |=> mode_fault_flag_reg)
      else $error("fault flag lost");
   tgt_abort_a: assert property (!ctrl_mode && ss_n_s && shifting |=>
      !shifting) else $error("target did not abort");
   ctrl_first_a: assert property (ctrl_start_s ##1 !fault_det |=>
      !byte_done) else $error("byte ended too soon");
   rate_fast_a: assert property (rate == 2'h0 && is_ctrl && tick &&
      !ctl_wr_in |=> !tick [*3]) else $error("wrong divider");
   idle_clk_a: assert property (!shifting |-> serial_clock_pin_out ==
      polarity) else $error("clock not idle at polarity");
   no_tgt_start_a: assert property (is_tgt && !tgt_sel |=> !shifting)
      else $error("target shifted unselected");
endmodule : spp_port

// ==== test/spp_tgt_model.sv ====
`timescale 1ns/10ps
// Far side target: shifts one byte per select in the chosen format
module spp_tgt_model (
   // Serial pins
   input wire logic sclk_in,
   input wire logic sel_n_in,
   input wire logic mosi_in,
   output logic miso_out,
   // Format and bytes
   input wire logic clock_polarity_in,
   input wire logic clock_phase_in,
   input wire logic lsb_in,
   input wire logic [7:0] tx_in,
   output logic [7:0] rx_out
);
   int k = 8;
   logic last = 1'b0;
   wire logic [2:0] idx = lsb_in ? 3'(k) : 3'(7 - k);
   wire logic live = !sel_n_in && k >= 0 && k < 8;
   // Phase 1 puts out its first bit only at the first clock edge
   always @(negedge sel_n_in) begin
      k = clock_phase_in ? -1 : 0;
   end
   // Sample on the leading edge in phase 0, the trailing one in phase 1;
   // the bit count frames the byte, as select may rise with the last edge
   always @(sclk_in) begin
      if (k < 8 && ((sclk_in != clock_polarity_in) ^ clock_phase_in)) begin
         rx_out = lsb_in ? {mosi_in, rx_out[7:1]}
                         : {rx_out[6:0], mosi_in};
      end else if (k < 8) begin
         k = k + 1;
      end
   end
   // Off the byte the line shows the inverse of its last bit, so a
   // controller that samples late never sees a plausible stale value
   always @* begin
      if (live) begin
         last = tx_in[idx];
      end
      miso_out = live ? last : ~last;
   end
endmodule : spp_tgt_model

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
// Port as controller against the model, then as target of the bench
module tb_top;
   localparam int H = 8;
   logic mclk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic ctl_wr = 1'b0, takeover = 1'b0, pirq = 1'b0, girq = 1'b0;
   logic data_wr = 1'b0, data_rd = 1'b0, b_sclk = 1'b0, b_mosi = 1'b0;
   logic b_sel_n = 1'b1;
   logic [3:0] clrs = 4'h0;
   logic [7:0] ctl_data = 8'h00, data_in = 8'h00, cfg = 8'h00;
   logic [7:0] m_tx = 8'h00, exp_rx = 8'h00, v, rx, ctl_q, data_q, m_rx;
   logic done, ovr, col, flt, busy, irq, sclk_o, sclk_oe, cd_o, cd_oe;
   logic td_o, td_oe, sel_o, sel_oe, m_miso;
   int seed = 17309;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;
   int f, i;
   // Wire levels from every party's enable; select idles high by pull-up
   wire logic sclk_w = sclk_oe ? sclk_o : b_sclk;
   wire logic mosi_w = cd_oe ? cd_o : b_mosi;
   wire logic miso_w = td_oe ? td_o : m_miso;
   wire logic sel_w = sel_oe ? sel_o : b_sel_n;

   spp_port uut (.mclk_in, .sys_rst_in, .ctl_wr_in(ctl_wr),
      .ctl_data_in(ctl_data), .ctl_out(ctl_q),
      .select_pin_takeover_in(takeover), .port_irq_enable_in(pirq),
      .global_irq_enable_in(girq), .data_wr_in(data_wr),
      .data_in(data_in), .data_rd_in(data_rd), .data_out(data_q),
      .done_clr_in(clrs[3]), .overrun_clr_in(clrs[2]),
      .collision_clr_in(clrs[1]), .fault_clr_in(clrs[0]),
      .transfer_done_flag_out(done), .overrun_flag_out(ovr),
      .write_collision_flag_out(col), .mode_fault_flag_out(flt),
      .busy_out(busy), .irq_out(irq), .serial_clock_pin_in(sclk_w),
      .serial_clock_pin_out(sclk_o), .serial_clock_pin_oe_out(sclk_oe),
      .ctrl_data_pin_in(mosi_w), .ctrl_data_pin_out(cd_o),
      .ctrl_data_pin_oe_out(cd_oe), .tgt_data_pin_in(miso_w),
      .tgt_data_pin_out(td_o), .tgt_data_pin_oe_out(td_oe),
      .select_n_pin_in(sel_w), .select_n_pin_out(sel_o),
      .select_n_pin_oe_out(sel_oe));

   spp_tgt_model model (.sclk_in(sclk_w), .sel_n_in(sel_w),
      .mosi_in(mosi_w), .miso_out(m_miso), .clock_polarity_in(cfg[3]),
      .clock_phase_in(cfg[2]), .lsb_in(cfg[5]), .tx_in(m_tx), .rx_out(m_rx));

   // Clock and hang guard
   always #10 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         wrap_up();
      end
   end

   task automatic wrap_up;
      if (error_cnt == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_bit(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask : chk_bit

   task automatic step(input int n);
      repeat (n) @(negedge mclk_in);
   endtask : step

   // Single cycle strobes, all launched on the falling edge
   task automatic set_ctl(input logic [7:0] d);
      @(negedge mclk_in);
      ctl_data = d;
      ctl_wr = 1'b1;
      @(negedge mclk_in);
      ctl_wr = 1'b0;
   endtask : set_ctl

   task automatic wr_data(input logic [7:0] d);
      @(negedge mclk_in);
      data_in = d;
      data_wr = 1'b1;
      @(negedge mclk_in);
      data_wr = 1'b0;
   endtask : wr_data

   // Mask is read, done, overrun, collision, fault
   task automatic clr(input logic [4:0] m);
      @(negedge mclk_in);
      {data_rd, clrs} = m;
      @(negedge mclk_in);
      {data_rd, clrs} = 5'h00;
   endtask : clr

   function automatic int half_of(input logic [1:0] r);
      return (r == 0 ? spp_pkg::DIV_R0 : r == 1 ? spp_pkg::DIV_R1 :
              r == 2 ? spp_pkg::DIV_R2 : spp_pkg::DIV_R3) / 2;
   endfunction : half_of

   function automatic int bi(input int j);
      return cfg[5] ? j : 7 - j;
   endfunction : bi

   function automatic logic [7:0] shin(input logic [7:0] r);
      return cfg[5] ? {miso_w, r[7:1]} : {r[6:0], miso_w};
   endfunction : shin

   // Controller byte against the model, counting serial clock edges;
   // keep means the read buffer must still hold the older byte
   task automatic ctl_xfer(input logic [7:0] d, input logic col_try,
                           input logic keep);
      int t;
      int tog = 0;
      int t0 = 0;
      int t1 = 0;
      logic s;
      m_tx = 8'($random(seed));
      if (!keep) exp_rx = m_tx;
      chk_bit(sclk_w, cfg[3]);
      wr_data(d);
      data_in = ~d;
      chk_bit(busy, 1'b1);
      s = sclk_w;
      for (t = 0; t < 3000 && done !== 1'b1; t++) begin
         @(negedge mclk_in);
         data_wr = col_try && t == 100;
         if (sclk_w !== s) begin
            if (tog == 0) t0 = t;
            t1 = t;
            tog++;
            s = sclk_w;
         end
      end
      chk(8'(tog), 8'h10);
      chk_bit(t1 - t0 == 15 * half_of(cfg[1:0]), 1'b1);
      chk_bit(done, 1'b1);
      chk_bit(busy, 1'b0);
      chk_bit(sclk_w, cfg[3]);
      chk(m_rx, d);
      chk(data_q, exp_rx);
   endtask : ctl_xfer

   // Bench as far controller; a short count aborts mid-byte
   task automatic tgt_xfer(input logic [7:0] d, input int nb,
                           input logic hold);
      int j;
      b_sclk = cfg[3];
      b_sel_n = 1'b0;
      b_mosi = d[bi(0)];
      step(H);
      for (j = 0; j < nb; j++) begin
         if (cfg[2]) b_mosi = d[bi(j)];
         else rx = shin(rx);
         b_sclk = ~cfg[3];
         step(H);
         if (cfg[2]) rx = shin(rx);
         else if (j < 7) b_mosi = d[bi(j + 1)];
         b_sclk = cfg[3];
         step(H);
      end
      b_sel_n = !hold;
      step(H);
   endtask : tgt_xfer

   // Main sequence: controller formats, select pin modes, target formats
   initial begin
      repeat (8) @(negedge mclk_in);
      sys_rst_in = 1'b0;
      takeover = 1'b1;
      for (f = 0; f < 4; f++) begin
         cfg = {2'b11, 1'($random(seed)), 1'b1, f[1], f[0], f[1:0]};
         set_ctl(8'h00);
         set_ctl(cfg);
         v = 8'($random(seed));
         ctl_xfer(v, f == 2, 1'b0);
         if (f == 0) begin
            for (i = 0; i < 4; i++) begin
               pirq = i[0];
               girq = i[1];
               step(1);
               chk_bit(irq, i == 3);
            end
            clr(5'h08);
            ctl_xfer(~v, 1'b0, 1'b1);
            chk_bit(ovr, 1'b1);
         end
         if (f == 2) begin
            step(40);
            chk_bit(col, 1'b1);
            clr(5'h02);
            chk_bit(col, 1'b0);
         end
         step(20);
         chk_bit(done, 1'b1);
         clr(5'h1C);
         chk_bit(done, 1'b0);
      end
      for (f = 0; f < 3; f++) begin
         takeover = f != 0;
         cfg = f == 2 ? 8'hD0 : 8'h50;
         set_ctl(8'h00);
         set_ctl(cfg);
         b_sel_n = 1'b0;
         step(6);
         chk_bit(flt, f == 0);
         chk(ctl_q, f == 0 ? 8'h00 : cfg);
         chk_bit(irq, f == 0);
         b_sel_n = 1'b1;
         step(20);
         chk_bit(flt, f == 0);
         clr(5'h01);
         chk_bit(flt, 1'b0);
      end
      takeover = 1'b0;
      for (f = 0; f < 4; f++) begin
         cfg = {2'b01, 1'($random(seed)), 1'b0, f[1], f[0], 2'b00};
         set_ctl(8'h00);
         set_ctl(cfg);
         m_tx = 8'($random(seed));
         wr_data(m_tx);
         step(60);
         chk_bit(sclk_oe, 1'b0);
         chk_bit(done, 1'b0);
         v = 8'($random(seed));
         tgt_xfer(v, 8, f[0]);
         chk(rx, m_tx);
         chk(data_q, v);
         chk_bit(done, 1'b1);
         clr(5'h18);
         v = 8'($random(seed));
         if (f[0]) begin
            tgt_xfer(v, 8, 1'b0);
         end else begin
            b_sel_n = 1'b0;
            step(4);
            wr_data(8'hA5);
            chk_bit(col, 1'b1);
            clr(5'h02);
            b_sel_n = 1'b1;
            step(H);
            tgt_xfer(8'h3C, 3, 1'b0);
            chk_bit(done, 1'b0);
            tgt_xfer(v, 8, 1'b0);
         end
         chk(data_q, v);
         clr(5'h18);
      end
      wrap_up();
   end
endmodule : tb_top
